// ==== hw/res_defs.svh ====
/*
 * Constants of the regulator enable sequencer: link register addresses,
 * field positions, reset values and timing counts.
 * Assumes a 100 MHz core clock.
 */
`ifndef RES_DEFS_SVH
`define RES_DEFS_SVH

`define RES_ADDR_W          4
`define RES_DATA_W          8
`define RES_CORE_W          7

`define RES_ADDR_CORE       4'h1
`define RES_ADDR_RETENTION  4'h2
`define RES_ADDR_IO         4'h7
`define RES_ADDR_PLL        4'h8
`define RES_ADDR_MODE       4'h9

`define RES_MODE_PFM_BIT    7
`define RES_MODE_PWM_BIT    6

`define RES_MODE_RST        8'h00
`define RES_PLL_RST         8'h10
`define RES_IO_RST          8'h20
`define RES_CORE_RST        7'h40
`define RES_RETENTION_RST   8'h08

`define RES_AUTO_DWELL      64
`define RES_ILIM_PFM_MA     100
`define RES_MEM_OFFSET_MV   50
`define RES_CLK_PERIOD_NS   10
`define RES_SEQ_STEP_NS     1000
`define RES_SEQ_STEP_CYC    ((`RES_SEQ_STEP_NS + `RES_CLK_PERIOD_NS - 1) / `RES_CLK_PERIOD_NS)

`endif

// ==== hw/res_pkg.sv ====
/*
 * Types of the regulator enable sequencer.
 * Assumes res_defs.svh for widths.
 */
`default_nettype none
`include "res_defs.svh"

package res_pkg;

    typedef enum logic [2:0] {
        ST_STARTUP,
        ST_RAMP,
        ST_ACTIVE,
        ST_SLEEP,
        ST_SHUTDOWN
    } res_state_type;

    typedef struct packed {
        logic shutdown;
        logic sleep;
        logic wakeup;
    } res_cmd_type;

    typedef struct packed {
        logic                   valid;
        logic [`RES_ADDR_W-1:0] addr;
        logic [`RES_DATA_W-1:0] data;
    } res_wr_type;

    typedef struct packed {
        logic core_en;
        logic pll_en;
        logic io_en;
        logic mem_en;
        logic mem_track;
        logic power_good;
    } res_rail_type;

endpackage

`default_nettype wire

// ==== hw/res_sequencer.sv ====
/*
 * Regulator enable sequencer: power state machine, power-up sequencing,
 * converter modulation mode choice and regulator level holding.
 * Assumes the link decoder runs on ref_clk and hands over decoded
 * commands and register writes as one-cycle strobes; pins are async.
 * Rail enables are plain levels: the analog side does its own soft
 * start, so each ramp step only has to outlast that settling time.
 * The light-load flag comes from the converter and is async as well.
 * Shutdown is left only through the pins, never through the link.
 */
// Behaviour
// - Auto choice between pulse-frequency and pulse-width
// - Force field overrides automatic modulation choice
// - Forced pulse-frequency lowers switch current limit
// - Shut down on low pins or command
// - Enabled only while both pins high
// - Enable runs power-up, restores default levels
// - Shutdown command also disables serial link
// - Four link-programmable supply level registers
// - Active: memory supply tracks converter plus offset
// - Sleep: memory supply uses retention level
// - Reset: start-up, rails off, power-good low
// - Active: all rails on, power-good high
// - Sleep drops core, wake resumes config
// - Shutdown: rails off, power-good low
`default_nettype none
`include "res_defs.svh"

module res_sequencer #(
    parameter int SEQ_STEP_CYCLES = `RES_SEQ_STEP_CYC,
    parameter int AUTO_DWELL      = `RES_AUTO_DWELL
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire logic                    enable_pin,
    input  wire logic                    global_reset_low,
    input  wire logic                    light_load,
    input  wire res_pkg::res_cmd_type    link_cmd,
    input  wire res_pkg::res_wr_type     link_wr,
    output logic                         link_active,
    output res_pkg::res_rail_type        rails,
    output logic                         power_good_out,
    output logic                         pfm_mode,
    output logic                         ilim_reduced,
    output logic [`RES_DATA_W-1:0]       pll_supply_level,
    output logic [`RES_DATA_W-1:0]       io_supply_level,
    output logic [`RES_CORE_W-1:0]       core_level,
    output logic [`RES_DATA_W-1:0]       retention_level,
    output res_pkg::res_state_type       state_out
);

    localparam int SEQ_W   = $clog2(SEQ_STEP_CYCLES + 1);
    localparam int DWELL_W = $clog2(AUTO_DWELL + 1);

    if (SEQ_STEP_CYCLES < 1) begin : g_chk_seq
        $error("SEQ_STEP_CYCLES must be at least 1");
    end
    if (AUTO_DWELL < 1) begin : g_chk_dwell
        $error("AUTO_DWELL must be at least 1");
    end
    // Core level is a slice of the link data byte
    if (`RES_CORE_W > `RES_DATA_W) begin : g_chk_core
        $error("core level wider than link data");
    end

    typedef struct packed {
        res_pkg::res_state_type  state;
        logic [1:0]              ramp_step;
        logic [SEQ_W-1:0]        seq_cnt;
        logic [2:0]              en_sync;
        logic [2:0]              grst_sync;
        logic [2:0]              load_sync;
        logic                    en_lvl;
        logic                    grst_lvl;
        logic                    load_lvl;
        logic [DWELL_W-1:0]      dwell_cnt;
        logic                    pfm_auto;
        logic [1:0]              mode_force;
        logic [`RES_DATA_W-1:0]  pll_lvl;
        logic [`RES_DATA_W-1:0]  io_lvl;
        logic [`RES_CORE_W-1:0]  core_lvl;
        logic [`RES_DATA_W-1:0]  ret_lvl;
        res_pkg::res_rail_type   rail;
        logic                    pfm;
        logic                    ilim_low;
        logic                    link_on;
    } res_regs_type;

    res_regs_type regs_r;
    res_regs_type regs_nxt;

    logic enabled;
    logic link_ok;
    logic wr_hit;

    always_comb begin
        regs_nxt = regs_r;

        // Zeroed stages read the pins low, so no false enable at reset
        // Three stages; a change counts once stages two and three agree
        regs_nxt.en_sync   = {regs_r.en_sync[1:0], enable_pin};
        regs_nxt.grst_sync = {regs_r.grst_sync[1:0], global_reset_low};
        regs_nxt.load_sync = {regs_r.load_sync[1:0], light_load};
        if (regs_r.en_sync[1] == regs_r.en_sync[2]) begin
            regs_nxt.en_lvl = regs_r.en_sync[2];
        end
        if (regs_r.grst_sync[1] == regs_r.grst_sync[2]) begin
            regs_nxt.grst_lvl = regs_r.grst_sync[2];
        end
        if (regs_r.load_sync[1] == regs_r.load_sync[2]) begin
            regs_nxt.load_lvl = regs_r.load_sync[2];
        end

        // Tied pins behave the same as one pin driven on both
        enabled = regs_r.en_lvl && regs_r.grst_lvl;

        // Link traffic only counts while the link is powered
        link_ok = regs_r.link_on;
        // Limitation: no read-back here; reads live in the decoder
        wr_hit  = link_ok && link_wr.valid;

        if (wr_hit) begin
            case (link_wr.addr)
                `RES_ADDR_MODE: begin
                    regs_nxt.mode_force =
                        link_wr.data[`RES_MODE_PFM_BIT:`RES_MODE_PWM_BIT];
                end
                `RES_ADDR_PLL: begin
                    regs_nxt.pll_lvl = link_wr.data;
                end
                `RES_ADDR_IO: begin
                    regs_nxt.io_lvl = link_wr.data;
                end
                `RES_ADDR_CORE: begin
                    regs_nxt.core_lvl = link_wr.data[`RES_CORE_W-1:0];
                end
                `RES_ADDR_RETENTION: begin
                    regs_nxt.ret_lvl = link_wr.data;
                end
                default: begin
                    // Unused addresses drop the write
                end
            endcase
        end

        // Light load must persist for the dwell before going to PFM
        // Limitation: only entry is delayed, exit from PFM is prompt
        if (!regs_r.load_lvl) begin
            regs_nxt.dwell_cnt = '0;
            regs_nxt.pfm_auto  = 1'b0;
        end else if (regs_r.dwell_cnt >= DWELL_W'(AUTO_DWELL - 1)) begin
            regs_nxt.pfm_auto  = 1'b1;
        end else begin
            regs_nxt.dwell_cnt = regs_r.dwell_cnt + 1'b1;
        end

        // Forced modes apply one cycle after the write lands
        case (regs_r.mode_force)
            2'h2: begin
                regs_nxt.pfm      = 1'b1;
                regs_nxt.ilim_low = 1'b1;
            end
            2'h1: begin
                regs_nxt.pfm      = 1'b0;
                regs_nxt.ilim_low = 1'b0;
            end
            default: begin
                // Auto keeps the normal limit even when in PFM
                regs_nxt.pfm      = regs_nxt.pfm_auto;
                regs_nxt.ilim_low = 1'b0;
            end
        endcase

        case (regs_r.state)
            res_pkg::ST_STARTUP: begin
                regs_nxt.rail    = '0;
                regs_nxt.link_on = 1'b0;
                // Levels reload on every entry, so a restart starts clean
                if (enabled) begin
                    regs_nxt.state      = res_pkg::ST_RAMP;
                    regs_nxt.ramp_step  = 2'h0;
                    regs_nxt.seq_cnt    = '0;
                    regs_nxt.mode_force =
                        2'(`RES_MODE_RST >> `RES_MODE_PWM_BIT);
                    regs_nxt.pll_lvl    = `RES_PLL_RST;
                    regs_nxt.io_lvl     = `RES_IO_RST;
                    regs_nxt.core_lvl   = `RES_CORE_RST;
                    regs_nxt.ret_lvl    = `RES_RETENTION_RST;
                end
            end
            res_pkg::ST_RAMP: begin
                // Core first, then PLL and I/O, then memory
                // Fixed step time; the rails give no settled feedback
                if (regs_r.seq_cnt >= SEQ_W'(SEQ_STEP_CYCLES - 1)) begin
                    regs_nxt.seq_cnt = '0;
                    case (regs_r.ramp_step)
                        2'h0: begin
                            regs_nxt.rail.core_en = 1'b1;
                        end
                        2'h1: begin
                            regs_nxt.rail.pll_en = 1'b1;
                            regs_nxt.rail.io_en  = 1'b1;
                        end
                        default: begin
                            // Link opens in the last step, in the same cycle as the memory rail and power-good
                            regs_nxt.rail.mem_en    = 1'b1;
                            regs_nxt.rail.mem_track = 1'b1;
                            regs_nxt.rail.power_good = 1'b1;
                            regs_nxt.link_on        = 1'b1;
                            regs_nxt.state = res_pkg::ST_ACTIVE;
                        end
                    endcase
                    regs_nxt.ramp_step = regs_r.ramp_step + 2'h1;
                end else begin
                    regs_nxt.seq_cnt = regs_r.seq_cnt + 1'b1;
                end
            end
            res_pkg::ST_ACTIVE: begin
                regs_nxt.rail.core_en    = 1'b1;
                regs_nxt.rail.pll_en     = 1'b1;
                regs_nxt.rail.io_en      = 1'b1;
                regs_nxt.rail.mem_en     = 1'b1;
                regs_nxt.rail.mem_track  = 1'b1;
                regs_nxt.rail.power_good = 1'b1;
                // Shutdown wins over sleep when both arrive together
                if (link_ok && link_cmd.shutdown) begin
                    // Link goes dead with the command, not a cycle later
                    regs_nxt.state   = res_pkg::ST_SHUTDOWN;
                    regs_nxt.link_on = 1'b0;
                end else if (link_ok && link_cmd.sleep) begin
                    regs_nxt.state = res_pkg::ST_SLEEP;
                end
            end
            res_pkg::ST_SLEEP: begin
                regs_nxt.rail.core_en    = 1'b0;
                regs_nxt.rail.pll_en     = 1'b1;
                regs_nxt.rail.io_en      = 1'b1;
                regs_nxt.rail.mem_en     = 1'b1;
                regs_nxt.rail.mem_track  = 1'b0;
                regs_nxt.rail.power_good = 1'b1;
                if (link_ok && link_cmd.shutdown) begin
                    regs_nxt.state   = res_pkg::ST_SHUTDOWN;
                    regs_nxt.link_on = 1'b0;
                end else if (link_ok && link_cmd.wakeup) begin
                    // Levels were kept, so active resumes as left
                    regs_nxt.state = res_pkg::ST_ACTIVE;
                end
            end
            res_pkg::ST_SHUTDOWN: begin
                // Rails stay off however much the host keeps talking
                regs_nxt.rail    = '0;
                regs_nxt.link_on = 1'b0;
                // Leaves only after a pin drops; host then raises it again
                if (!enabled) begin
                    regs_nxt.state = res_pkg::ST_STARTUP;
                end
            end
            default: begin
                regs_nxt.state = res_pkg::ST_STARTUP;
            end
        endcase

        // Pins win over everything else, any state
        // Pin loss mid-ramp aborts the ramp with every rail dropped
        if (!enabled && regs_r.state != res_pkg::ST_SHUTDOWN) begin
            regs_nxt.state   = res_pkg::ST_STARTUP;
            regs_nxt.rail    = '0;
            regs_nxt.link_on = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // Levels reset too, so they read sane before any enable
            regs_r            <= '0;
            regs_r.state      <= res_pkg::ST_STARTUP;
            regs_r.pll_lvl    <= `RES_PLL_RST;
            regs_r.io_lvl     <= `RES_IO_RST;
            regs_r.core_lvl   <= `RES_CORE_RST;
            regs_r.ret_lvl    <= `RES_RETENTION_RST;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // Every output is a flop, so rail enables never glitch
    assign link_active      = regs_r.link_on;
    assign rails            = regs_r.rail;
    assign power_good_out   = regs_r.rail.power_good;
    assign pfm_mode         = regs_r.pfm;
    assign ilim_reduced     = regs_r.ilim_low;
    assign pll_supply_level = regs_r.pll_lvl;
    assign io_supply_level  = regs_r.io_lvl;
    assign core_level       = regs_r.core_lvl;
    assign retention_level  = regs_r.ret_lvl;
    assign state_out        = regs_r.state;

endmodule // res_sequencer

`default_nettype wire

// ==== test/res_ctrl_model.sv ====
/* Controller model: drives the enable pins and the decoded link strobes.
   Assumes the bench calls its tasks; changes only at falling edges. */
`default_nettype none
module res_ctrl_model (
    input  wire logic           ref_clk,
    output logic                enable_pin,
    output logic                global_reset_low,
    output res_pkg::res_cmd_type link_cmd,
    output res_pkg::res_wr_type  link_wr
);
    initial begin
        enable_pin = 1'h0;
        global_reset_low = 1'h0;
        link_cmd = 3'h0;
        link_wr = 13'h0AAA;
    end
    task automatic set_pins(input logic en, input logic rn);
        @(negedge ref_clk);
        enable_pin = en;
        global_reset_low = rn;
    endtask
    task automatic send_cmd(input res_pkg::res_cmd_type c);
        @(negedge ref_clk);
        link_cmd = c;
        @(negedge ref_clk);
        link_cmd = 3'h0;
    endtask
    task automatic send_wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        link_wr = {1'h1, a, d};
        @(negedge ref_clk);
        // Released fields show inverse data, never a stale match
        link_wr = {1'h0, ~a, ~d};
    endtask
    task automatic toggle_en();
        set_pins(1'h0, global_reset_low);
        repeat (6) @(negedge ref_clk);
        set_pins(1'h1, global_reset_low);
    endtask
endmodule // res_ctrl_model
`default_nettype wire

// ==== test/res_sequencer_assertions.sv ====
/* Port checker of res_sequencer.
   Assumes one clock domain; bound below. */
`default_nettype none
`include "res_defs.svh"
module res_sequencer_assertions #(
    parameter int SEQ_STEP_CYCLES = 2,
    parameter int AUTO_DWELL      = 4
) (
    input wire logic                   ref_clk,
    input wire logic                   rst,
    input wire logic                   enable_pin,
    input wire logic                   global_reset_low,
    input wire res_pkg::res_cmd_type   link_cmd,
    input wire res_pkg::res_wr_type    link_wr,
    input wire logic                   link_active,
    input wire res_pkg::res_rail_type  rails,
    input wire logic                   power_good_out,
    input wire logic                   pfm_mode,
    input wire logic                   ilim_reduced,
    input wire logic [7:0]             pll_supply_level,
    input wire logic [7:0]             io_supply_level,
    input wire logic [6:0]             core_level,
    input wire res_pkg::res_state_type state_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Rails lag state by one cycle, so only steady states are judged
    property p_off; state_out inside {res_pkg::ST_STARTUP,
        res_pkg::ST_SHUTDOWN} && $stable(state_out)
        |-> rails == 6'h00 && !power_good_out && !link_active; endproperty
    a_off: assert property (p_off) else $error("rails on while off");
    property p_act; state_out == res_pkg::ST_ACTIVE && $stable(state_out)
        |-> rails == 6'h3F && power_good_out; endproperty
    a_act: assert property (p_act) else $error("active rails");
    property p_slp; state_out == res_pkg::ST_SLEEP && $stable(state_out)
        |-> rails == 6'h1D && power_good_out; endproperty
    a_slp: assert property (p_slp) else $error("sleep rails");
    property p_pins; (!enable_pin || !global_reset_low) [*8]
        |-> state_out inside {res_pkg::ST_STARTUP, res_pkg::ST_SHUTDOWN};
    endproperty
    a_pins: assert property (p_pins) else $error("up with pin low");
    property p_shut; link_active && link_cmd.shutdown
        |=> state_out == res_pkg::ST_SHUTDOWN; endproperty
    a_shut: assert property (p_shut) else $error("no shutdown");
    property p_ramp; state_out == res_pkg::ST_RAMP && $stable(state_out)
        |-> pll_supply_level == `RES_PLL_RST && io_supply_level ==
        `RES_IO_RST && core_level == `RES_CORE_RST; endproperty
    a_ramp: assert property (p_ramp) else $error("levels not default");
    property p_pll; link_active && link_wr.valid && link_wr.addr ==
        `RES_ADDR_PLL |=> pll_supply_level == $past(link_wr.data);
    endproperty
    a_pll: assert property (p_pll) else $error("pll level");
    property p_fpfm; link_active && link_wr.valid && link_wr.addr ==
        `RES_ADDR_MODE && link_wr.data[7:6] == 2'h2
        |-> ##2 pfm_mode && ilim_reduced; endproperty
    a_fpfm: assert property (p_fpfm) else $error("forced pfm");
    property p_fpwm; link_active && link_wr.valid && link_wr.addr ==
        `RES_ADDR_MODE && link_wr.data[7:6] == 2'h1
        |-> ##2 !pfm_mode && !ilim_reduced; endproperty
    a_fpwm: assert property (p_fpwm) else $error("forced pwm");
endmodule // res_sequencer_assertions
bind res_sequencer res_sequencer_assertions #(
    .SEQ_STEP_CYCLES(SEQ_STEP_CYCLES), .AUTO_DWELL(AUTO_DWELL)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .enable_pin(enable_pin),
    .global_reset_low(global_reset_low), .link_cmd(link_cmd),
    .link_wr(link_wr), .link_active(link_active), .rails(rails),
    .power_good_out(power_good_out), .pfm_mode(pfm_mode),
    .ilim_reduced(ilim_reduced), .pll_supply_level(pll_supply_level),
    .io_supply_level(io_supply_level), .core_level(core_level),
    .state_out(state_out));
`default_nettype wire

// ==== test/regulator_enable_sequencer_bench.sv ====
/* Self-checking bench of res_sequencer with a controller model.
   Assumes package, model and checker compiled first. */
`default_nettype none
`include "res_defs.svh"
module regulator_enable_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DWELL = 4;
    logic                   ref_clk;
    logic                   rst;
    logic                   light_load;
    logic                   enable_pin;
    logic                   global_reset_low;
    res_pkg::res_cmd_type   link_cmd;
    res_pkg::res_wr_type    link_wr;
    logic                   link_active;
    res_pkg::res_rail_type  rails;
    logic                   power_good_out;
    logic                   pfm_mode;
    logic                   ilim_reduced;
    logic [7:0]             pll_lvl;
    logic [7:0]             io_lvl;
    logic [6:0]             core_lvl;
    logic [7:0]             ret_lvl;
    res_pkg::res_state_type state_out;
    int                     miscompares;
    int                     n_tests;
    int                     cycles;
    logic [31:0]            seed;
    logic [7:0]             exp_pll;
    logic [7:0]             exp_io;
    logic [7:0]             exp_core;
    logic [7:0]             exp_ret;
`define CHK(act, exp, msg) begin \
    n_tests++; \
    if ((act) !== (exp)) begin \
        miscompares++; \
        $display("MISMATCH %0t %s", $time, msg); \
    end \
end
    res_ctrl_model m (.ref_clk(ref_clk), .enable_pin(enable_pin),
        .global_reset_low(global_reset_low), .link_cmd(link_cmd),
        .link_wr(link_wr));
    // Short step and dwell keep the run brief
    res_sequencer #(.SEQ_STEP_CYCLES(2), .AUTO_DWELL(DWELL)) uut (
        .ref_clk(ref_clk), .rst(rst), .enable_pin(enable_pin),
        .global_reset_low(global_reset_low), .light_load(light_load),
        .link_cmd(link_cmd), .link_wr(link_wr), .link_active(link_active),
        .rails(rails), .power_good_out(power_good_out), .pfm_mode(pfm_mode),
        .ilim_reduced(ilim_reduced), .pll_supply_level(pll_lvl),
        .io_supply_level(io_lvl), .core_level(core_lvl),
        .retention_level(ret_lvl),
        .state_out(state_out));
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    function automatic logic [7:0] upd(input logic [3:0] a,
        input logic [3:0] t, input logic [7:0] d, input logic [7:0] c);
        return (a == t) ? d : c;
    endfunction
    function automatic logic exp_pfm(input logic [1:0] f, input logic ll);
        return (f == 2'h2) || ((f[1] == f[0]) && ll);
    endfunction
    task automatic wait_st(input res_pkg::res_state_type s);
        int n;
        n = 0;
        while (state_out !== s && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(state_out, s, "state")
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            $display("MISMATCH %0t timeout", $time);
            report_and_stop();
        end
    end
    initial begin
        rst = 1'h1;
        light_load = 1'h0;
        miscompares = 0;
        n_tests = 0;
        cycles = 0;
        seed = 32'h17;
        exp_pll = `RES_PLL_RST;
        exp_io = `RES_IO_RST;
        exp_core = {1'h0, `RES_CORE_RST};
        exp_ret = `RES_RETENTION_RST;
        repeat (4) @(negedge ref_clk);
        rst = 1'h0;
        repeat (8) @(negedge ref_clk);
        `CHK({state_out, rails}, {res_pkg::ST_STARTUP, 6'h00}, "reset")
        m.set_pins(1'h1, 1'h1);
        wait_st(res_pkg::ST_ACTIVE);
        @(negedge ref_clk);
        `CHK({rails, pll_lvl, io_lvl}, {6'h3F, exp_pll, exp_io}, "up")
        `CHK({1'h0, core_lvl, ret_lvl}, {exp_core, exp_ret}, "up lvl")
        // Every address once, reserved and unmapped ones included
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            light_load = seed[12];
            m.send_wr(i[3:0], seed[7:0]);
            exp_pll = upd(i[3:0], `RES_ADDR_PLL, seed[7:0], exp_pll);
            exp_io = upd(i[3:0], `RES_ADDR_IO, seed[7:0], exp_io);
            `CHK({pll_lvl, io_lvl}, {exp_pll, exp_io}, "level")
            exp_core = upd(i[3:0], `RES_ADDR_CORE, {1'h0, seed[6:0]},
                exp_core);
            exp_ret = upd(i[3:0], `RES_ADDR_RETENTION, seed[7:0],
                exp_ret);
            `CHK({1'h0, core_lvl, ret_lvl}, {exp_core, exp_ret}, "cr")
        end
        for (int i = 0; i < 4; i++) begin
            light_load = 1'h1;
            m.send_wr(`RES_ADDR_MODE, {i[1:0], 6'h00});
            repeat (DWELL + 12) @(negedge ref_clk);
            `CHK({pfm_mode, ilim_reduced}, {exp_pfm(i[1:0], 1'h1), i == 2}, "hi")
            light_load = 1'h0;
            repeat (10) @(negedge ref_clk);
            `CHK({pfm_mode, ilim_reduced}, {exp_pfm(i[1:0], 1'h0), i == 2}, "lo")
        end
        m.send_cmd(3'h2);
        wait_st(res_pkg::ST_SLEEP);
        @(negedge ref_clk);
        `CHK({rails, power_good_out}, {6'h1D, 1'h1}, "sleep")
        m.send_cmd(3'h1);
        wait_st(res_pkg::ST_ACTIVE);
        `CHK({pll_lvl, io_lvl}, {exp_pll, exp_io}, "resume")
        m.set_pins(1'h1, 1'h0);
        wait_st(res_pkg::ST_STARTUP);
        @(negedge ref_clk);
        `CHK(rails, 6'h00, "pin off")
        m.set_pins(1'h1, 1'h1);
        wait_st(res_pkg::ST_ACTIVE);
        exp_pll = `RES_PLL_RST;
        exp_io = `RES_IO_RST;
        exp_core = {1'h0, `RES_CORE_RST};
        exp_ret = `RES_RETENTION_RST;
        `CHK({pll_lvl, io_lvl}, {exp_pll, exp_io}, "defaults")
        `CHK({1'h0, core_lvl, ret_lvl}, {exp_core, exp_ret}, "dflt")
        m.send_cmd(3'h4);
        wait_st(res_pkg::ST_SHUTDOWN);
        m.send_wr(`RES_ADDR_PLL, 8'hA5);
        repeat (20) @(negedge ref_clk);
        `CHK({state_out, link_active, pll_lvl},
             {res_pkg::ST_SHUTDOWN, 1'h0, exp_pll}, "off")
        m.toggle_en();
        wait_st(res_pkg::ST_ACTIVE);
        m.set_pins(1'h0, 1'h1);
        m.set_pins(1'h1, 1'h1);
        repeat (12) @(negedge ref_clk);
        `CHK(state_out, res_pkg::ST_ACTIVE, "glitch")
        m.set_pins(1'h0, 1'h0);
        wait_st(res_pkg::ST_STARTUP);
        report_and_stop();
    end
endmodule // regulator_enable_sequencer_bench
`default_nettype wire
